//--- asc_regs.vh
`ifndef ASC_REGS_VH
`define ASC_REGS_VH
// Register indices; the byte address on the bus is four times the index
`define ASC_CTL_OFS      8'h30
`define ASC_RES1_OFS     8'h31
`define ASC_RES2_OFS     8'h32
`define ASC_RES3_OFS     8'h33
`define ASC_RES4_OFS     8'h34
// Byte address bits that reach the decoder (index in bits 9:2)
`define ASC_ADDR_W       10
// Control/status fields
`define ASC_DONE_BIT     7
`define ASC_SCAN_BIT     5
`define ASC_MULTI_CHANNEL_SELECT_BIT     4
`define ASC_CTL_RESET    8'h00
// Conversion slot timing in bus cycles
`define ASC_SLOT_CYC     6'd32
`define ASC_SAMPLE_CYC   6'd12
`define ASC_BIT_CYC      6'd2
`define ASC_START_DLY    1
`endif

//--- asc_sar.v
`timescale 1ns/100ps
// ****************************************
// Successive approximation engine
// ****************************************
module asc_sar (
  // Clock and reset
  input  wire       hclk,
  input  wire       hresetn,
  // Control
  input  wire       start,
  input  wire       abort,
  input  wire       hold,
  // Comparator
  input  wire       cmp_above,
  // Outputs
  output reg  [7:0] dac_code,
  output reg        sampling,
  output reg        done,
  output reg  [7:0] result
);
`include "asc_regs.vh"
  reg [5:0] cyc;
  reg       busy;
  reg [2:0] bitn;
  // Comparator switches on this clock, so it is read directly: two more
  // flip-flops would make every decision after the first one stale
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cyc      <= 6'h00;
      busy     <= 1'b0;
      bitn     <= 3'h7;
      dac_code <= 8'h00;
      sampling <= 1'b0;
      done     <= 1'b0;
      result   <= 8'h00;
    end else begin
      done <= 1'b0;
      if (abort || start || hold) begin
        // Suspend restarts the slot so the channel is sampled again
        cyc      <= 6'h00;
        busy     <= !abort && (start || (busy && hold));
        bitn     <= 3'h7;
        dac_code <= 8'h80;
        // Gate stays shut while held and reopens on resume
        sampling <= !abort && start;
      end else if (busy) begin
        cyc <= cyc + 6'h01;
        sampling <= (cyc < `ASC_SAMPLE_CYC - 6'h01);
        if (cyc >= `ASC_SAMPLE_CYC && cyc[0] &&
            cyc < `ASC_SAMPLE_CYC + 6'd16) begin
          // MSB first, one decision every two cycles
          if (!cmp_above) begin
            dac_code[bitn] <= 1'b0;
          end
          if (bitn != 3'h0) begin
            dac_code[bitn - 3'h1] <= 1'b1;
          end
          bitn <= bitn - 3'h1;
        end
        if (cyc == `ASC_SLOT_CYC - 6'h01) begin
          busy   <= 1'b0;
          done   <= 1'b1;
          result <= dac_code;
        end
      end
    end
  end
endmodule

//--- asc_top.v
`timescale 1ns/100ps
module asc_top (
  // AHB-Lite clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // System state
  input  wire        converter_power_up,
  input  wire        low_power_mode,
  // Analog front end
  input  wire        comparator_above,
  output reg  [3:0]  analog_channel,
  output reg  [7:0]  dac_value,
  output reg         sample_gate
);
`include "asc_regs.vh"
  // ****************************************
  // Bus slave
  // ****************************************
  reg        ap_write;
  reg [7:0]  ap_addr;
  wire [7:0] addr_idx;
  reg [7:0]  ctl;
  reg        done_flag;
  reg [7:0]  res [0:3];
  reg        pwr_q1;
  reg        pwr_q2;
  reg        lp_q1;
  reg        lp_q2;
  reg        start_req;
  reg        run;
  reg [1:0]  slot;
  wire       take;
  wire       ctl_wr;
  wire       sar_done;
  wire [7:0] sar_result;
  wire [7:0] sar_dac;
  wire       sar_samp;
  wire       hold;
  reg  [7:0] rd_mux;
  reg  [3:0] next_channel;
  assign take     = hsel && hready && htrans[1];
  assign addr_idx = haddr[`ASC_ADDR_W-1:2];
  assign ctl_wr = ap_write && (ap_addr == `ASC_CTL_OFS);
  assign hold   = lp_q2 && run;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_write  <= 1'b0;
      ap_addr   <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      ap_write <= take && hwrite;
      ap_addr  <= addr_idx;
    end
  end
  always @* begin
    rd_mux = 8'h00;
    case (addr_idx)
      // Bit 6 forced to zero
      `ASC_CTL_OFS:  rd_mux = {done_flag, 1'b0, ctl[5:0]};
      `ASC_RES1_OFS: rd_mux = res[0];
      `ASC_RES2_OFS: rd_mux = res[1];
      `ASC_RES3_OFS: rd_mux = res[2];
      `ASC_RES4_OFS: rd_mux = res[3];
      default:       rd_mux = 8'h00;
    endcase
  end
  // Read data is taken at the address phase so it stands in the data phase;
  // a read right behind a control write still sees the old settings
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (take && !hwrite) begin
      hrdata <= {24'h000000, rd_mux};
    end
  end
  // ****************************************
  // Synchronisers
  // ****************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwr_q1 <= 1'b0;
      pwr_q2 <= 1'b0;
      lp_q1  <= 1'b0;
      lp_q2  <= 1'b0;
    end else begin
      pwr_q1 <= converter_power_up;
      pwr_q2 <= pwr_q1;
      lp_q1  <= low_power_mode;
      lp_q2  <= lp_q1;
    end
  end
  // ****************************************
  // Sequencer
  // ****************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl       <= `ASC_CTL_RESET;
      done_flag <= 1'b0;
      start_req <= 1'b0;
      run       <= 1'b0;
      slot      <= 2'b00;
    end else begin
      start_req <= 1'b0;
      if (ctl_wr) begin
        ctl       <= {2'b00, hwdata[5:0]};
        done_flag <= 1'b0;
        slot      <= 2'b00;
        run       <= pwr_q2;
        // Start one cycle after the write lands
        start_req <= pwr_q2;
      end else if (!pwr_q2) begin
        run <= 1'b0;
      end else if (run && sar_done) begin
        slot <= slot + 2'b01;
        if (slot == 2'b11) begin
          done_flag <= 1'b1;
          if (!ctl[`ASC_SCAN_BIT]) begin
            run <= 1'b0;
          end else begin
            start_req <= 1'b1;
          end
        end else begin
          start_req <= 1'b1;
        end
      end else if (run && start_req && hold) begin
        start_req <= 1'b1;
      end
    end
  end
  // Result registers have no reset; contents are undefined until written
  always @(posedge hclk) begin
    if (run && sar_done && !ctl_wr) begin
      res[slot] <= sar_result;
    end
  end
  always @* begin
    if (ctl[`ASC_MULTI_CHANNEL_SELECT_BIT]) begin
      next_channel = {ctl[3:2], slot};
    end else begin
      next_channel = ctl[3:0];
    end
  end
  // Codes 0-7 external inputs, 12-14 references, others reserved
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      analog_channel <= 4'h0;
      dac_value      <= 8'h00;
      sample_gate    <= 1'b0;
    end else begin
      analog_channel <= next_channel;
      dac_value      <= sar_dac;
      sample_gate    <= sar_samp && run;
    end
  end
  asc_sar u_sar (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .start     (start_req && !hold),
    .abort     (ctl_wr || !pwr_q2),
    .hold      (hold),
    .cmp_above (comparator_above),
    .dac_code  (sar_dac),
    .sampling  (sar_samp),
    .done      (sar_done),
    .result    (sar_result)
  );
endmodule

//--- asc_analog.sv
`timescale 1ns/100ps
// ****************
// Analog front end
// ****************
module asc_analog (
  // Converter side
  input  wire [3:0] analog_channel,
  input  wire [7:0] dac_value,
  output wire       comparator_above
);
  // Each channel gets its own level, so a wrong channel shows in the code
  assign comparator_above =
    ({4'h0, analog_channel} * 8'hF + 8'h9) > dac_value;
endmodule

//--- asc_checker.sv
`timescale 1ns/100ps
// ****************
// Port checker
// ****************
module asc_checker (
  // Bus
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  // Converter
  input wire        converter_power_up,
  input wire        low_power_mode,
  input wire [7:0]  dac_value,
  input wire        sample_gate
);
  reg  wr_ctl;
  reg  rd_ctl;
  wire hit = hsel & hready & htrans[1] & (haddr[9:2] == 8'h30);
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ctl <= 1'h0;
      rd_ctl <= 1'h0;
    end else begin
      wr_ctl <= hit & hwrite;
      rd_ctl <= hit & ~hwrite;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_bus; hreadyout && !hresp; endproperty
  a_bus: assert property (p_bus) else $error("bus not OKAY");
  property p_bit6; rd_ctl |-> hrdata[6] == 1'h0; endproperty
  a_bit6: assert property (p_bit6) else $error("bit 6 set");
  property p_start;
    wr_ctl && converter_power_up && !low_power_mode |-> ##[1:4] sample_gate;
  endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_samp; $rose(sample_gate) |-> sample_gate [*8]; endproperty
  a_samp: assert property (p_samp) else $error("short sample");
  property p_gap; $fell(sample_gate) |-> !sample_gate [*8]; endproperty
  a_gap: assert property (p_gap) else $error("short slot");
  property p_msb; $fell(sample_gate) |-> ##[0:2] dac_value == 8'h80; endproperty
  a_msb: assert property (p_msb) else $error("no MSB trial");
  property p_off; !converter_power_up [*5] |-> !sample_gate; endproperty
  a_off: assert property (p_off) else $error("runs unpowered");
  property p_susp; low_power_mode [*5] |-> !sample_gate; endproperty
  a_susp: assert property (p_susp) else $error("not suspended");
  c_wr: cover property (wr_ctl);
  c_susp: cover property (low_power_mode ##1 !low_power_mode);
  c_off: cover property (!converter_power_up);
endmodule
bind asc_top asc_checker u_asc_checker (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .converter_power_up(converter_power_up), .low_power_mode(low_power_mode),
  .dac_value(dac_value), .sample_gate(sample_gate));

//--- tb.sv
`timescale 1ns/100ps
`include "asc_regs.vh"
// ****************
// Testbench
// ****************
module tb;
  reg         hclk = 1'h0;
  reg         hresetn = 1'h0;
  reg         hsel = 1'h0;
  reg  [31:0] haddr = 32'h0;
  reg  [1:0]  htrans = 2'h0;
  reg         hwrite = 1'h0;
  reg  [31:0] hwdata = 32'h0;
  reg         converter_power_up = 1'h1;
  reg         low_power_mode = 1'h0;
  wire [31:0] hrdata;
  wire        hreadyout;
  wire        hresp;
  wire        comparator_above;
  wire        sample_gate;
  wire [3:0]  analog_channel;
  wire [7:0]  dac_value;
  integer     n_errors = 0;
  integer     samples_checked = 0;
  integer     i;
  reg  [31:0] rd;
  reg  [31:0] rnd;
  asc_top u_asc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp),
    .converter_power_up(converter_power_up),
    .low_power_mode(low_power_mode), .comparator_above(comparator_above),
    .analog_channel(analog_channel), .dac_value(dac_value),
    .sample_gate(sample_gate));
  asc_analog u_asc_analog (.analog_channel(analog_channel),
    .dac_value(dac_value), .comparator_above(comparator_above));
  initial forever #5 hclk = ~hclk;
  // Converts one level below the channel's level, as comparison is strict
  function [31:0] res_of(input [5:0] c, input [1:0] k);
    res_of = {28'h0, c[4] ? {c[3:2], k} : c[3:0]} * 32'hF + 32'h8;
  endfunction
  task test_done;
    $display("Checks %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task hang;
    n_errors = n_errors + 1;
    test_done;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wait_rdy;
    integer n;
    n = 0;
    do begin
      @(posedge hclk);
      n = n + 1;
    end while (hreadyout !== 1'h1 && n < 50);
    if (n >= 50) hang;
  endtask
  task xfer(input w, input [7:0] a, input [31:0] d);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, a, 2'h0};
    wait_rdy;
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    rd = hrdata;
  endtask
  task run(input [5:0] c);
    integer k;
    integer m;
    xfer(1'h1, `ASC_CTL_OFS, {26'h0, c});
    m = 0;
    rd = 32'h0;
    while (rd[7] !== 1'h1) begin
      repeat (10) @(posedge hclk);
      xfer(1'h0, `ASC_CTL_OFS, 32'h0);
      m = m + 1;
      if (m > 40) hang;
    end
    chk(rd, {24'h0, 2'h2, c});
    m = 0;
    repeat (64) begin
      @(negedge hclk);
      m = m + sample_gate;
    end
    @(posedge hclk);
    chk({31'h0, m != 0}, {31'h0, c[5]});
    for (k = 0; k < 4; k = k + 1) begin
      xfer(1'h1, `ASC_RES1_OFS + k[7:0], $urandom);
      xfer(1'h0, `ASC_RES1_OFS + k[7:0], 32'h0);
      chk(rd, res_of(c, k[1:0]));
    end
    $display("Test cfg %h done", c);
  endtask
  initial begin
    void'($urandom(40));
    repeat (2) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    xfer(1'h0, `ASC_CTL_OFS, 32'h0);
    chk(rd & 32'h40, 32'h0);
    xfer(1'h0, 8'h35, 32'h0);
    chk(rd, 32'h0);
    $display("Test reset done");
    run(6'h0F);
    run(6'h1C);
    for (i = 0; i < 6; i = i + 1) begin
      rnd = $urandom;
      run({i[1:0], rnd[3:0]});
    end
    // A new write clears the flag, then a second one aborts mid-slot
    xfer(1'h1, `ASC_CTL_OFS, 32'h23);
    xfer(1'h0, `ASC_CTL_OFS, 32'h0);
    chk(rd & 32'h80, 32'h0);
    repeat (56) @(posedge hclk);
    run(6'h17);
    fork
      run(6'h19);
      begin
        repeat (55) @(posedge hclk);
        // Left as a wait exit, so no settling time is owed
        low_power_mode <= 1'h1;
        repeat (30) @(posedge hclk);
        low_power_mode <= 1'h0;
      end
    join
    converter_power_up <= 1'h0;
    repeat (4) @(posedge hclk);
    xfer(1'h1, `ASC_CTL_OFS, 32'h2C);
    repeat (200) @(posedge hclk);
    xfer(1'h0, `ASC_CTL_OFS, 32'h0);
    chk(rd & 32'h80, 32'h0);
    $display("Test power done");
    converter_power_up <= 1'h1;
    repeat (4) @(posedge hclk);
    run(6'h2C);
    test_done;
  end
endmodule
